// file: design/adcso_consts.svh
`ifndef ADCSO_CONSTS_SVH
`define ADCSO_CONSTS_SVH

// register offsets (byte addresses)
`define ADCSO_OFS_SEQLEN  8'h2C
`define ADCSO_OFS_SLOT_HI 8'h30
`define ADCSO_OFS_SLOT_LO 8'h34
`define ADCSO_OFS_RESULT  8'h4C
`define ADCSO_OFS_OVSCTL  8'h80
`define ADCSO_OFS_CTRL    8'h84

// reset value shared by every register
`define ADCSO_RST_VAL 32'h0000_0000

// writable bit masks, reserved bits stay zero
`define ADCSO_SLOT_MASK   32'h3FFF_FFFF
`define ADCSO_SEQLEN_MASK 32'h00F0_0000
`define ADCSO_OVSCTL_MASK 32'h0000_33FD
`define ADCSO_CTRL_MASK   32'h0000_0001

// field positions
`define ADCSO_SLOT_W      5
`define ADCSO_SLOTS_PER   6
`define ADCSO_SEQLEN_LSB  20
`define ADCSO_RES_LSB     12
`define ADCSO_TRIGGERED_OVERSAMPLING_BIT    9
`define ADCSO_SHIFT_LSB   5
`define ADCSO_RATIO_LSB   2
`define ADCSO_OVERSAMPLER_ENABLE_BIT   0
`define ADCSO_CONV_ON_BIT 0
`define ADCSO_BUSY_BIT    8
`define ADCSO_IDX_LSB     12

// limits
`define ADCSO_LAST_SLOT 4'hB
`define ADCSO_MAX_SHIFT 4'h8

`endif

// file: design/adcso_pkg.sv
package adcso_pkg;
  typedef enum logic [2:0] {
    S_IDLE,
    S_CONV,
    S_WAIT,
    S_WAIT_TRIG
  } adcso_state_t;
endpackage

// file: design/adcso_reg_if.sv
`timescale 1ns/1ps
interface adcso_reg_if;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        err;
  modport bus  (output wr, addr, wdata, input rdata, err);
  modport regs (input wr, addr, wdata, output rdata, err);
endinterface

// file: design/adcso_apb.sv
`timescale 1ns/1ps
module adcso_apb (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  adcso_reg_if.bus         ri
);
  logic access;

  // one wait state; the write lands on the edge that completes the access
  always_comb begin
    access   = psel & penable & ~pready;
    ri.addr  = paddr;
    ri.wdata = pwdata;
    ri.wr    = psel & penable & pwrite & pready & ~ri.err;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access & ri.err;
      if (access) begin
        prdata <= pwrite ? 32'h0000_0000 : ri.rdata;
      end
    end
  end
endmodule

// file: design/adcso_ovs_acc.sv
`timescale 1ns/1ps
`include "adcso_consts.svh"
module adcso_ovs_acc #(
  parameter int DW = 16,
  parameter int AW = 24
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          add,
  input  wire logic          first,
  input  wire logic [DW-1:0] data,
  input  wire logic [3:0]    shift,
  output logic      [DW-1:0] total
);
  logic [AW-1:0] acc;
  logic [AW-1:0] sum;
  logic [3:0]    sh;

  // reserved shift codes act as the largest shift
  always_comb begin
    sum   = (first ? '0 : acc) + AW'(data);
    sh    = (shift > `ADCSO_MAX_SHIFT) ? `ADCSO_MAX_SHIFT : shift;
    total = DW'(sum >> sh);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc <= '0;
    end else if (add) begin
      acc <= sum;
    end
  end
endmodule

// file: design/adcso_regs.sv
// Behaviour
// [RULE_01] each 5-bit slot holds channel 0..17; slot n is the nth conversion
// [RULE_02] slots 6..11 register: 5-bit fields from bit 0, bits 31:30 reserved
// [RULE_03] slots 0..5 register: 5-bit fields from bit 0, bits 31:30 reserved
// [RULE_04] software writes reserved bits only as zero
// [RULE_05] software uses only full 32-bit word accesses
// [RULE_06] result bits 15:0 hold latest conversion, read only, writes ignored
// [RULE_07] first instance in sync mode: bits 31:16 hold partner result
// [RULE_08] resolution field 13:12 selects 12, 10, 8 or 6 bits
// [RULE_09] triggered oversampling: each conversion waits its own trigger
// [RULE_10] shift field 8:5 right-shifts the oversampled sum, 0..8 bits
// [RULE_11] ratio field 4:2 selects 2x up to 256x oversampling
// [RULE_12] bit 0 enables the oversampler, set and cleared by software
// [RULE_13] software changes oversampler fields only while converter is off
// [RULE_14] sequence runs length plus one conversions from slot 0 upward
// [RULE_15] oversampling sums ratio results, shifts, writes the result field
`timescale 1ns/1ps
`include "adcso_consts.svh"
module adcso_regs #(
  parameter bit FIRST_INSTANCE = 1'b1
) (
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        TRIG,
  input  wire logic        CONV_DONE,
  input  wire logic [15:0] CONV_DATA,
  input  wire logic        SYNC_MODE,
  input  wire logic        PARTNER_VALID,
  input  wire logic [15:0] PARTNER_DATA,
  output logic             CONV_REQ,
  output logic      [4:0]  CONV_CHANNEL,
  output logic      [1:0]  CONV_RES,
  output logic             SEQ_BUSY,
  output logic             SEQ_END
);
  adcso_reg_if ri ();

  logic [31:0] slots_hi;
  logic [31:0] slots_lo;
  logic [31:0] seq_len_reg;
  logic [31:0] ovs_ctl;
  logic [31:0] routine_result;
  logic        converter_on;

  adcso_pkg::adcso_state_t state;

  logic [3:0]  slot_idx;
  logic [7:0]  ovs_cnt;
  logic [4:0]  slot_ch [12];
  logic [4:0]  cur_ch;
  logic [3:0]  seq_len;
  logic [3:0]  last_slot;
  logic        ovs_en;
  logic        triggered_oversampling;
  logic [2:0]  ratio;
  logic [3:0]  shift;
  logic [7:0]  ratio_last;
  logic        done_now;
  logic        last_conv;
  logic        last_in_seq;
  logic        res_load;
  logic        wait_next;
  logic [15:0] ovs_total;

  adcso_apb u_apb (
    .clk     (CLK_SYS),
    .nrst    (NRST),
    .psel    (PSEL),
    .penable (PENABLE),
    .pwrite  (PWRITE),
    .paddr   (PADDR),
    .pwdata  (PWDATA),
    .prdata  (PRDATA),
    .pready  (PREADY),
    .pslverr (PSLVERR),
    .ri      (ri.bus)
  );

  adcso_ovs_acc #(
    .DW (16),
    .AW (24)
  ) u_acc (
    .clk   (CLK_SYS),
    .nrst  (NRST),
    .add   (done_now),
    .first (ovs_cnt == 8'h00),
    .data  (CONV_DATA),
    .shift (shift),
    .total (ovs_total)
  );

  // slot table: low register carries slots 0..5, high register 6..11
  for (genvar i = 0; i < 12; i++) begin : g_slot
    if (i < `ADCSO_SLOTS_PER) begin : g_lo
      assign slot_ch[i] = slots_lo[i*`ADCSO_SLOT_W +: `ADCSO_SLOT_W]; // see [RULE_03]
    end else begin : g_hi
      assign slot_ch[i] =
        slots_hi[(i-`ADCSO_SLOTS_PER)*`ADCSO_SLOT_W +: `ADCSO_SLOT_W]; // see [RULE_02]
    end
  end

  always_comb begin
    seq_len    = seq_len_reg[`ADCSO_SEQLEN_LSB +: 4];
    last_slot  = (seq_len > `ADCSO_LAST_SLOT) ? `ADCSO_LAST_SLOT : seq_len;
    ovs_en     = ovs_ctl[`ADCSO_OVERSAMPLER_ENABLE_BIT]; // see [RULE_12]
    triggered_oversampling       = ovs_ctl[`ADCSO_TRIGGERED_OVERSAMPLING_BIT];
    ratio      = ovs_ctl[`ADCSO_RATIO_LSB +: 3];
    shift      = ovs_ctl[`ADCSO_SHIFT_LSB +: 4]; // see [RULE_10]
    ratio_last = 8'((16'h0002 << ratio) - 16'h0001); // see [RULE_11]
    cur_ch     = slot_ch[slot_idx];
    done_now   = (state == adcso_pkg::S_WAIT) && CONV_DONE;
    last_conv  = !ovs_en || (ovs_cnt == ratio_last);
    last_in_seq = slot_idx == last_slot;
    res_load   = done_now && last_conv;
    wait_next  = ovs_en && triggered_oversampling; // see [RULE_09]
  end

  // register read mux and address decode
  always_comb begin
    ri.err   = 1'b0;
    ri.rdata = 32'h0000_0000;
    case (ri.addr)
      `ADCSO_OFS_SEQLEN:  ri.rdata = seq_len_reg;
      `ADCSO_OFS_SLOT_HI: ri.rdata = slots_hi;
      `ADCSO_OFS_SLOT_LO: ri.rdata = slots_lo;
      `ADCSO_OFS_RESULT:  ri.rdata = routine_result;
      `ADCSO_OFS_OVSCTL:  ri.rdata = ovs_ctl;
      `ADCSO_OFS_CTRL: begin
        ri.rdata[`ADCSO_CONV_ON_BIT]  = converter_on;
        ri.rdata[`ADCSO_BUSY_BIT]     = state != adcso_pkg::S_IDLE;
        ri.rdata[`ADCSO_IDX_LSB +: 4] = slot_idx;
      end
      default: ri.err = 1'b1;
    endcase
  end

  // configuration registers; reserved bits are dropped on write
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      slots_hi     <= `ADCSO_RST_VAL;
      slots_lo     <= `ADCSO_RST_VAL;
      seq_len_reg  <= `ADCSO_RST_VAL;
      ovs_ctl      <= `ADCSO_RST_VAL;
      converter_on <= 1'b0;
    end else if (ri.wr) begin
      case (ri.addr)
        `ADCSO_OFS_SLOT_HI: slots_hi <= ri.wdata & `ADCSO_SLOT_MASK; // see [RULE_02]
        `ADCSO_OFS_SLOT_LO: slots_lo <= ri.wdata & `ADCSO_SLOT_MASK; // see [RULE_03]
        `ADCSO_OFS_SEQLEN:  seq_len_reg <= ri.wdata & `ADCSO_SEQLEN_MASK;
        `ADCSO_OFS_OVSCTL:  ovs_ctl <= ri.wdata & `ADCSO_OVSCTL_MASK; // see [RULE_12]
        `ADCSO_OFS_CTRL:    converter_on <= ri.wdata[`ADCSO_CONV_ON_BIT];
        default: begin
        end
      endcase
    end
  end

  // resolution goes straight to the converter core
  always_comb begin
    CONV_RES = ovs_ctl[`ADCSO_RES_LSB +: 2]; // see [RULE_08]
  end

  // sequence state machine
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state <= adcso_pkg::S_IDLE;
    end else if (!converter_on) begin
      state <= adcso_pkg::S_IDLE;
    end else begin
      case (state)
        adcso_pkg::S_IDLE: begin
          if (TRIG) begin
            state <= adcso_pkg::S_CONV;
          end
        end
        adcso_pkg::S_WAIT_TRIG: begin
          if (TRIG) begin
            state <= adcso_pkg::S_CONV; // see [RULE_09]
          end
        end
        adcso_pkg::S_CONV: begin
          state <= adcso_pkg::S_WAIT;
        end
        adcso_pkg::S_WAIT: begin
          if (CONV_DONE) begin
            if (last_conv && last_in_seq) begin
              state <= adcso_pkg::S_IDLE; // see [RULE_14]
            end else if (wait_next) begin
              state <= adcso_pkg::S_WAIT_TRIG; // see [RULE_09]
            end else begin
              state <= adcso_pkg::S_CONV;
            end
          end
        end
        default: state <= adcso_pkg::S_IDLE;
      endcase
    end
  end

  // slot walk and oversample count
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      slot_idx <= 4'h0;
      ovs_cnt  <= 8'h00;
    end else if (state == adcso_pkg::S_IDLE) begin
      slot_idx <= 4'h0; // see [RULE_14]
      ovs_cnt  <= 8'h00;
    end else if (done_now) begin
      if (!last_conv) begin
        ovs_cnt <= ovs_cnt + 8'h01; // see [RULE_11]
      end else begin
        ovs_cnt  <= 8'h00;
        slot_idx <= last_in_seq ? 4'h0 : slot_idx + 4'h1; // see [RULE_14]
      end
    end
  end

  // conversion request towards the core
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      CONV_REQ     <= 1'b0;
      CONV_CHANNEL <= 5'h00;
    end else begin
      CONV_REQ <= state == adcso_pkg::S_CONV;
      if (state == adcso_pkg::S_CONV) begin
        CONV_CHANNEL <= cur_ch; // see [RULE_01]
      end
    end
  end

  // status outputs
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      SEQ_BUSY <= 1'b0;
      SEQ_END  <= 1'b0;
    end else begin
      SEQ_BUSY <= state != adcso_pkg::S_IDLE;
      SEQ_END  <= res_load && last_in_seq;
    end
  end

  // result register; the bus never writes it
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      routine_result <= `ADCSO_RST_VAL;
    end else begin
      if (res_load) begin
        routine_result[15:0] <= ovs_en ? ovs_total : CONV_DATA; // see [RULE_06] [RULE_15]
      end
      if (!FIRST_INSTANCE || !SYNC_MODE) begin
        routine_result[31:16] <= 16'h0000; // see [RULE_07]
      end else if (PARTNER_VALID) begin
        routine_result[31:16] <= PARTNER_DATA; // see [RULE_07]
      end
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  property p_slot_channel;
    state == adcso_pkg::S_CONV |=> CONV_REQ && CONV_CHANNEL == $past(cur_ch);
  endproperty
  a_slot_channel: assert property (p_slot_channel) // see [RULE_01]
    else $error("channel sent does not match slot");

  property p_slot_hi;
    ri.wr && ri.addr == `ADCSO_OFS_SLOT_HI
      |=> slots_hi == ($past(PWDATA) & `ADCSO_SLOT_MASK) && slot_ch[6] == slots_hi[4:0];
  endproperty
  a_slot_hi: assert property (p_slot_hi) // see [RULE_02]
    else $error("high slot register write wrong");

  property p_slot_lo;
    ri.wr && ri.addr == `ADCSO_OFS_SLOT_LO
      |=> slots_lo[31:30] == 2'b00 && slot_ch[5] == $past(PWDATA[29:25]);
  endproperty
  a_slot_lo: assert property (p_slot_lo) // see [RULE_03]
    else $error("low slot register write wrong");

  property p_result_ro;
    ri.wr && ri.addr == `ADCSO_OFS_RESULT && !res_load |=> $stable(routine_result[15:0]);
  endproperty
  a_result_ro: assert property (p_result_ro) // see [RULE_06]
    else $error("result changed by a bus write");

  property p_partner;
    FIRST_INSTANCE && SYNC_MODE && PARTNER_VALID
      |=> routine_result[31:16] == $past(PARTNER_DATA);
  endproperty
  a_partner: assert property (p_partner) // see [RULE_07]
    else $error("partner result not captured");

  property p_res_field;
    ri.wr && ri.addr == `ADCSO_OFS_OVSCTL |=> CONV_RES == $past(PWDATA[13:12]);
  endproperty
  a_res_field: assert property (p_res_field) // see [RULE_08]
    else $error("resolution not forwarded");

  property p_trig_wait;
    done_now && !last_conv && wait_next
      |=> state == adcso_pkg::S_WAIT_TRIG ##0 !CONV_REQ [*2];
  endproperty
  a_trig_wait: assert property (p_trig_wait) // see [RULE_09]
    else $error("oversampled conversion did not wait for trigger");

  property p_ratio_count;
    ovs_cnt <= ratio_last;
  endproperty
  a_ratio_count: assert property (p_ratio_count) // see [RULE_11]
    else $error("oversample count past ratio");

  property p_raw_result;
    done_now && !ovs_en |=> routine_result[15:0] == $past(CONV_DATA);
  endproperty
  a_raw_result: assert property (p_raw_result) // see [RULE_12]
    else $error("raw conversion not stored");

  property p_ovs_result;
    res_load && ovs_en |=> routine_result[15:0] == $past(ovs_total);
  endproperty
  a_ovs_result: assert property (p_ovs_result) // see [RULE_15]
    else $error("oversampled result not stored");

  property p_seq_end;
    res_load && last_in_seq |=> SEQ_END && state == adcso_pkg::S_IDLE && slot_idx == 4'h0;
  endproperty
  a_seq_end: assert property (p_seq_end) // see [RULE_14]
    else $error("sequence did not end at its length");

  c_seq_end: cover property (SEQ_END);
  c_ovs_done: cover property (res_load && ovs_en && ratio == 3'h1);
  c_trig_wait: cover property (state == adcso_pkg::S_WAIT_TRIG ##[1:20] CONV_REQ);
endmodule

// file: sim/adcso_regs_tb.sv
`timescale 1ns/1ps
module adcso_regs_tb;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] r;
    logic        e;
  } adcso_row_t;

  logic        CLK_SYS, NRST, PSEL, PENABLE, PWRITE, TRIG, CONV_DONE;
  logic        SYNC_MODE, PARTNER_VALID, PREADY, PSLVERR, CONV_REQ, SEQ_BUSY, SEQ_END;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [15:0] CONV_DATA, PARTNER_DATA, nd;
  logic [4:0]  CONV_CHANNEL, cur_ch;
  logic [1:0]  CONV_RES;
  logic        err;
  int          failures, n_compared, cyc, dly;
  logic [4:0]  ch_q[$];
  logic [15:0] dat_q[$];
  logic [4:0]  exp_ch[12] = '{0, 1, 2, 3, 4, 17, 6, 7, 8, 9, 10, 11};
  // mapped registers get reserved bits written as zero only
  adcso_row_t  rows[6] = '{
    '{8'h30, 32'h3FFF_FFFF, 32'h3FFF_FFFF, 1'b0},
    '{8'h34, 32'h3FFF_FFFF, 32'h3FFF_FFFF, 1'b0},
    '{8'h80, 32'h0000_33FD, 32'h0000_33FD, 1'b0},
    '{8'h4C, 32'h1234_5678, 32'h0000_0000, 1'b0},
    '{8'h40, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1},
    '{8'h2C, 32'h00F0_0000, 32'h00F0_0000, 1'b0}};

  adcso_regs DUT (
    .CLK_SYS(CLK_SYS), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .TRIG(TRIG), .CONV_DONE(CONV_DONE),
    .CONV_DATA(CONV_DATA), .SYNC_MODE(SYNC_MODE), .PARTNER_VALID(PARTNER_VALID),
    .PARTNER_DATA(PARTNER_DATA), .CONV_REQ(CONV_REQ), .CONV_CHANNEL(CONV_CHANNEL),
    .CONV_RES(CONV_RES), .SEQ_BUSY(SEQ_BUSY), .SEQ_END(SEQ_END));

  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end

  // converter core stand-in: answers each request three cycles later
  always @(posedge CLK_SYS) begin
    CONV_DONE <= 1'b0;
    if (CONV_REQ === 1'b1) begin
      cur_ch = CONV_CHANNEL;
      ch_q.push_back(CONV_CHANNEL);
      dly = 3;
    end else if (dly > 0) begin
      dly--;
      if (dly == 0) begin
        nd = 16'h0100 + {11'h000, cur_ch} + 16'(dat_q.size()) * 16'h0010;
        dat_q.push_back(nd);
        CONV_DATA <= nd;
        CONV_DONE <= 1'b1;
      end
    end
  end

  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      $display("mismatch at %0t: timeout", $time);
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_count(input int got, input int exp, input string m);
    n_compared++;
    if (got != exp) begin
      failures++;
      $display("mismatch at %0t: %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    chk_count(n, 2, "bus answer");
  endtask

  task automatic pulse_trig();
    @(posedge CLK_SYS);
    TRIG <= 1'b1;
    @(posedge CLK_SYS);
    TRIG <= 1'b0;
  endtask

  task automatic wait_end();
    int n;
    n = 0;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (SEQ_END !== 1'b1 && n < 3000);
    chk_count(n < 3000, 1, "sequence end");
  endtask

  // converter off while the oversampler is reconfigured
  task automatic setup(input logic [3:0] len, input logic [31:0] ovs);
    apb(1'b1, 8'h84, 32'h0000_0000);
    apb(1'b1, 8'h80, ovs);
    apb(1'b1, 8'h2C, {8'h00, len, 20'h0_0000});
    apb(1'b1, 8'h84, 32'h0000_0001);
    ch_q.delete();
    dat_q.delete();
  endtask

  function automatic logic [31:0] acc(input int sh);
    logic [31:0] s;
    s = 32'h0000_0000;
    foreach (dat_q[i]) s = s + {16'h0000, dat_q[i]};
    return {16'h0000, 16'(s >> sh)};
  endfunction

  initial begin
    {NRST, PSEL, PENABLE, PWRITE, TRIG, SYNC_MODE, PARTNER_VALID} = 7'h00;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    PARTNER_DATA = 16'h0000;
    repeat (8) @(posedge CLK_SYS);
    NRST <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk_word(rd, 32'h0000_0000, "reset value");
    end
    $display("test reset values done");
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      chk_word({31'h0, err}, {31'h0, rows[i].e}, "write error");
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk_word(rd, rows[i].r, "readback");
      chk_word({31'h0, err}, {31'h0, rows[i].e}, "read error");
    end
    $display("test register rows done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 8'h80, 32'(k) << 12);
      @(negedge CLK_SYS);
      chk_word({30'h0, CONV_RES}, 32'(k), "resolution");
    end
    $display("test resolution done");
    apb(1'b1, 8'h34, 32'h2241_8820);
    apb(1'b1, 8'h30, 32'h16A4_A0E6);
    setup(4'hB, 32'h0000_0000);
    pulse_trig();
    wait_end();
    chk_count(ch_q.size(), 12, "conversions");
    foreach (ch_q[i]) chk_word({27'h0, ch_q[i]}, {27'h0, exp_ch[i]}, "channel");
    apb(1'b0, 8'h4C, 32'h0000_0000);
    chk_word(rd, {16'h0000, dat_q[$]}, "result");
    setup(4'h0, 32'h0000_0000);
    pulse_trig();
    wait_end();
    chk_count(ch_q.size(), 1, "single conversion");
    $display("test sequence done");
    setup(4'h0, 32'h0000_0045);
    pulse_trig();
    wait_end();
    chk_count(ch_q.size(), 4, "ratio 4x");
    apb(1'b0, 8'h4C, 32'h0000_0000);
    chk_word(rd, acc(2), "oversampled");
    setup(4'h0, 32'h0000_011D);
    pulse_trig();
    wait_end();
    chk_count(ch_q.size(), 256, "ratio 256x");
    apb(1'b0, 8'h4C, 32'h0000_0000);
    chk_word(rd, acc(8), "shift 8");
    $display("test oversampling done");
    @(posedge CLK_SYS);
    SYNC_MODE <= 1'b1;
    PARTNER_DATA <= 16'hBEEF;
    PARTNER_VALID <= 1'b1;
    @(posedge CLK_SYS);
    PARTNER_VALID <= 1'b0;
    apb(1'b0, 8'h4C, 32'h0000_0000);
    chk_word(rd, 32'hBEEF_0000 | acc(8), "partner result");
    $display("test sync mode done");
    setup(4'h0, 32'h0000_0201);
    pulse_trig();
    repeat (30) @(posedge CLK_SYS);
    chk_count(ch_q.size(), 1, "one per trigger");
    chk_word({31'h0, SEQ_BUSY}, 32'h0000_0001, "busy while waiting");
    pulse_trig();
    wait_end();
    chk_count(ch_q.size(), 2, "two triggers");
    apb(1'b0, 8'h4C, 32'h0000_0000);
    chk_word(rd[15:0], acc(0), "triggered sum");
    $display("test triggered done");
    setup(4'hB, 32'h0000_0000);
    pulse_trig();
    repeat (10) @(posedge CLK_SYS);
    NRST <= 1'b0;
    @(negedge CLK_SYS);
    chk_word({30'h0, SEQ_BUSY, CONV_REQ}, 32'h0000_0000, "reset outputs");
    @(posedge CLK_SYS);
    NRST <= 1'b1;
    apb(1'b0, 8'h34, 32'h0000_0000);
    chk_word(rd, 32'h0000_0000, "slots after reset");
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
